// ===== src/iic_ctrl_pkg.sv
// Purpose: Shared constants and types for the serial mode and interrupt-enable block.
// Assumes: 8-bit registers on a 32-bit APB, register index times four is the byte address.
// Notes: Pin timing counts derive from the link clock period.
`default_nettype none
package iic_ctrl_pkg;
  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] MODE_IDX = 8'hBA;
  localparam logic [7:0] IEN_IDX = 8'hBB;
  localparam logic [7:0] LINE_IDX = 8'hC0;
  localparam logic [7:0] CFG_IDX = 8'hC1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h18;
  localparam logic [7:0] IEN_RESET = 8'h00;

  // ==========================================================================
  // Field positions, mode control
  localparam int MODE_PROT_BIT = 3;
  localparam int MODE_RSV_BIT = 5;
  localparam int MODE_WAIT_BIT = 6;
  localparam int MODE_ORDER_BIT = 7;
  // Field positions, interrupt enable
  localparam int IEN_ACKT_BIT = 0;
  localparam int IEN_ACKR_BIT = 1;
  localparam int IEN_JUDGE_BIT = 2;
  localparam int IEN_STOP_BIT = 3;
  localparam int IEN_NACK_BIT = 4;
  localparam int IEN_RX_BIT = 5;
  localparam int IEN_TEND_BIT = 6;
  localparam int IEN_TEMPTY_BIT = 7;
  // Field positions, line control
  localparam int LINE_SCLMON_BIT = 3;
  localparam int LINE_PROT_BIT = 4;
  localparam int LINE_LEVEL_BIT = 5;
  localparam int LINE_GDIS_BIT = 6;
  localparam int LINE_BUSY_BIT = 7;
  // Field positions, link configuration
  localparam int CFG_SYNC_BIT = 0;
  localparam int CFG_MASTER_BIT = 1;
  localparam int CFG_TX_BIT = 2;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 125;
  localparam int LINK_CYCLES = (LINK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_CYCLES = 2 * LINK_CYCLES;
  localparam int CNT_W = 6;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_START = 2'b01,
    GEN_STOP_LOW = 2'b11,
    GEN_STOP_REL = 2'b10
  } gen_e;

  typedef struct packed {
    logic stop_seen;
    logic nack_seen;
    logic arb_lost;
    logic rx_full;
    logic tx_end;
    logic tx_empty;
  } flags_s;

  typedef struct packed {
    logic stop_req;
    logic nack_req;
    logic rx_req;
    logic tx_end_req;
    logic tx_empty_req;
  } irq_s;
endpackage : iic_ctrl_pkg
`default_nettype wire

// ===== src/pin_sync.sv
// Purpose: Two-stage synchroniser for pins from outside the clock domain.
// Assumes: Inputs are slow levels relative to pclk.
// Notes: Only the second stage is visible outside.
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // ==========================================================================
  // Two flops; idle bus lines rest high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '1;
      sync_out <= '1;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ===== src/irq_gate.sv
// Purpose: Gates status flags with enables into registered interrupt requests.
// Assumes: Flags are levels from the shift engine on pclk.
// Notes: Requests follow flags one cycle later.
`default_nettype none
module irq_gate (
  input wire logic pclk,
  input wire logic presetn,
  input wire iic_ctrl_pkg::flags_s flags,
  input wire logic [7:0] enables,
  input wire logic sync_format,
  output iic_ctrl_pkg::irq_s irq
);
  iic_ctrl_pkg::irq_s next_irq;

  // ==========================================================================
  // Request equations
  // stop gated by enable
  assign next_irq.stop_req = enables[iic_ctrl_pkg::IEN_STOP_BIT] & flags.stop_seen;
  assign next_irq.nack_req = enables[iic_ctrl_pkg::IEN_NACK_BIT] &
                             (flags.nack_seen | flags.arb_lost);
  assign next_irq.rx_req = enables[iic_ctrl_pkg::IEN_RX_BIT] &
                           (flags.rx_full | (flags.arb_lost & sync_format));
  assign next_irq.tx_end_req = enables[iic_ctrl_pkg::IEN_TEND_BIT] & flags.tx_end;
  assign next_irq.tx_empty_req = enables[iic_ctrl_pkg::IEN_TEMPTY_BIT] & flags.tx_empty;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= '0;
    end else begin
      irq <= next_irq;
    end
  end
endmodule : irq_gate
`default_nettype wire

// ===== src/iic_mode_ctrl.sv
// Purpose: Mode control, interrupt enables and bit-level transfer control for a two-wire link.
// Assumes: APB with one wait state; SCL is made by an outside divider and only stretched here.
// Notes: Open-drain pins: output enable low means the pin is pulled low.
`default_nettype none
module iic_mode_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [7:0] tx_data,
  output logic [7:0] rx_data,
  output logic transfer_halted,
  input wire iic_ctrl_pkg::flags_s flags,
  output iic_ctrl_pkg::irq_s irq
);
  // ==========================================================================
  // Elaboration checks
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 10 to 32");
  end

  // ==========================================================================
  // Counter coding and register address match
  // Bit count from code, I2C or sync format
  function automatic logic [3:0] bc_decode(input logic [2:0] code, input logic sync);
    if (code == 3'h0) begin
      bc_decode = sync ? 4'h8 : 4'h9;
    end else begin
      bc_decode = sync ? {1'b0, code} : {1'b0, code} + 4'h1;
    end
  endfunction : bc_decode

  function automatic logic [2:0] bc_encode(input logic [3:0] left, input logic sync);
    if (sync) begin
      // A count left over from I2C (nine) also reads as a full byte
      bc_encode = (left >= 4'h8) ? 3'h0 : left[2:0];
    end else begin
      bc_encode = (left >= 4'h9 || left == 4'h1) ? 3'h0 : 3'(left - 4'h1);
    end
  endfunction : bc_encode

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    reg_hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (addr[1:0] == 2'h0);
  endfunction : reg_hit

  // ==========================================================================
  // State
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic [3:0] left;
  logic order_lsb;
  logic wait_en;
  logic rsv_bit;
  logic [7:0] ien;
  logic line_level;
  logic bus_busy_flag;
  logic sync_fmt;
  logic master;
  logic transmit;
  logic halt;
  logic armed;
  logic [iic_ctrl_pkg::CNT_W-1:0] wait_cnt;
  logic [iic_ctrl_pkg::CNT_W-1:0] gen_cnt;
  iic_ctrl_pkg::gen_e gen_state;
  iic_ctrl_pkg::gen_e next_gen;
  logic sda_low;
  logic next_sda_low;

  // ==========================================================================
  // Pin synchronisers and edge detection
  pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Remember last synced pin levels for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  wire scl_fall = scl_d & ~scl_s;
  wire scl_rise = ~scl_d & scl_s;
  wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_seen = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================================
  // APB decode
  wire setup = psel & ~penable;
  wire done = psel & penable & pready;
  wire wr = done & pwrite;
  wire hit_mode = reg_hit(paddr, iic_ctrl_pkg::MODE_IDX);
  wire hit_ien = reg_hit(paddr, iic_ctrl_pkg::IEN_IDX);
  wire hit_line = reg_hit(paddr, iic_ctrl_pkg::LINE_IDX);
  wire hit_cfg = reg_hit(paddr, iic_ctrl_pkg::CFG_IDX);
  wire hit_any = hit_mode | hit_ien | hit_line | hit_cfg;
  wire wr_mode = wr & hit_mode;
  wire wr_ien = wr & hit_ien;
  wire wr_line = wr & hit_line;
  wire wr_cfg = wr & hit_cfg;

  wire bc_write = wr_mode & ~pwdata[iic_ctrl_pkg::MODE_PROT_BIT];
  wire level_write = wr_line & ~pwdata[iic_ctrl_pkg::LINE_PROT_BIT];
  // master, I2C, disable zero, generator free
  wire gen_write = wr_line & ~pwdata[iic_ctrl_pkg::LINE_GDIS_BIT] & master & ~sync_fmt &
                   (gen_state == iic_ctrl_pkg::GEN_IDLE);
  wire gen_start = gen_write & pwdata[iic_ctrl_pkg::LINE_BUSY_BIT];
  wire gen_stop = gen_write & ~pwdata[iic_ctrl_pkg::LINE_BUSY_BIT];

  localparam int IEN_ACKR = iic_ctrl_pkg::IEN_ACKR_BIT;

  // Read views; protect and disable bits read as one
  wire [7:0] mode_view = {order_lsb, wait_en, rsv_bit, 1'b1, 1'b1, bc_encode(left, sync_fmt)};
  wire [7:0] ien_view = {ien[7:2], ien[IEN_ACKR], ien[0]};
  wire [7:0] line_view = {bus_busy_flag, 1'b1, line_level, 1'b1, scl_s, 3'h0};
  wire [7:0] cfg_view = {5'h00, transmit, master, sync_fmt};
  wire [7:0] read_mux = hit_mode ? mode_view :
                        hit_ien ? ien_view :
                        hit_line ? line_view :
                        hit_cfg ? cfg_view : 8'h00;

  // One wait state: answer registered during setup so outputs are flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit_any;
      prdata <= setup ? {24'h00_0000, read_mux} : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Plain software settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      order_lsb <= iic_ctrl_pkg::MODE_RESET[iic_ctrl_pkg::MODE_ORDER_BIT];
      wait_en <= iic_ctrl_pkg::MODE_RESET[iic_ctrl_pkg::MODE_WAIT_BIT];
      rsv_bit <= iic_ctrl_pkg::MODE_RESET[iic_ctrl_pkg::MODE_RSV_BIT];
      sync_fmt <= 1'b0;
      master <= 1'b0;
      transmit <= 1'b0;
      line_level <= 1'b1;
    end else begin
      if (wr_mode) begin
        order_lsb <= pwdata[iic_ctrl_pkg::MODE_ORDER_BIT];
        wait_en <= pwdata[iic_ctrl_pkg::MODE_WAIT_BIT];
        rsv_bit <= pwdata[iic_ctrl_pkg::MODE_RSV_BIT];
      end
      if (wr_cfg) begin
        sync_fmt <= pwdata[iic_ctrl_pkg::CFG_SYNC_BIT];
        master <= pwdata[iic_ctrl_pkg::CFG_MASTER_BIT];
        transmit <= pwdata[iic_ctrl_pkg::CFG_TX_BIT];
      end
      if (level_write) begin
        line_level <= pwdata[iic_ctrl_pkg::LINE_LEVEL_BIT];
      end
    end
  end

  // ==========================================================================
  // Bit position within the frame
  wire active = sync_fmt | bus_busy_flag;
  wire ack_phase = ~sync_fmt & (left == 4'h1);
  wire [3:0] data_left = sync_fmt ? left : left - 4'h1;
  wire [2:0] bit_idx = 3'(4'h8 - data_left);
  // zero MSB first, one LSB first
  wire [2:0] shift_pos = order_lsb ? bit_idx : 3'(3'h7 - bit_idx);
  wire tx_bit = tx_data[shift_pos];
  // The fall right after a start opens bit one, so it is not a bit end
  wire count_fall = scl_fall & active & ~halt & (armed | sync_fmt);
  wire last_data_fall = count_fall & ~sync_fmt & (left == 4'h2);

  // Armed by the first rise of a frame, cleared by a start condition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (start_seen) begin
      armed <= 1'b0;
    end else if (scl_rise & active) begin
      armed <= 1'b1;
    end
  end

  // ==========================================================================
  // Counter, acknowledge, halt and receive shifting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 4'h9;
      ien <= iic_ctrl_pkg::IEN_RESET;
      halt <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      if (wr_ien) begin
        ien[7:2] <= pwdata[7:2];
        ien[iic_ctrl_pkg::IEN_ACKT_BIT] <= pwdata[iic_ctrl_pkg::IEN_ACKT_BIT];
      end
      if (bc_write) begin
        left <= bc_decode(pwdata[2:0], sync_fmt);
        halt <= 1'b0;
      end else if (count_fall) begin
        // back to 000 after the last bit
        left <= (left == 4'h1) ? bc_decode(3'h0, sync_fmt) : left - 4'h1;
      end else if (stop_seen) begin
        halt <= 1'b0;
      end
      if (scl_rise & active & ~halt) begin
        if (ack_phase & transmit) begin
          ien[IEN_ACKR] <= sda_s;
          if (ien[iic_ctrl_pkg::IEN_JUDGE_BIT] & sda_s & ~bc_write) begin
            halt <= 1'b1;
          end
        end else if (~ack_phase & ~transmit) begin
          rx_data[shift_pos] <= sda_s;
        end
      end
    end
  end

  // ==========================================================================
  // Wait insertion after the final data bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= '0;
    end else if (last_data_fall & wait_en & master) begin
      wait_cnt <= iic_ctrl_pkg::CNT_W'(iic_ctrl_pkg::WAIT_CYCLES);
    end else if (wait_cnt != '0) begin
      wait_cnt <= wait_cnt - 1'b1;
    end
  end

  // ==========================================================================
  // Bus occupancy seen on the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_busy_flag <= 1'b0;
    end else if (start_seen) begin
      bus_busy_flag <= 1'b1;
    end else if (stop_seen) begin
      bus_busy_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Start and stop generator
  always_comb begin
    next_gen = gen_state;
    unique case (gen_state)
      iic_ctrl_pkg::GEN_IDLE: begin
        if (gen_start) begin
          next_gen = iic_ctrl_pkg::GEN_START;
        end else if (gen_stop) begin
          next_gen = iic_ctrl_pkg::GEN_STOP_LOW;
        end
      end
      iic_ctrl_pkg::GEN_START: begin
        if (gen_cnt == '0) begin
          next_gen = iic_ctrl_pkg::GEN_IDLE;
        end
      end
      iic_ctrl_pkg::GEN_STOP_LOW: begin
        if (scl_s & (gen_cnt == '0)) begin
          next_gen = iic_ctrl_pkg::GEN_STOP_REL;
        end
      end
      iic_ctrl_pkg::GEN_STOP_REL: begin
        next_gen = iic_ctrl_pkg::GEN_IDLE;
      end
    endcase
  end

  // Hold each condition for one link period so slow parties see it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_state <= iic_ctrl_pkg::GEN_IDLE;
      gen_cnt <= '0;
    end else begin
      gen_state <= next_gen;
      if (gen_state != next_gen) begin
        gen_cnt <= iic_ctrl_pkg::CNT_W'(iic_ctrl_pkg::LINK_CYCLES);
      end else if (gen_cnt != '0 && (gen_state != iic_ctrl_pkg::GEN_STOP_LOW || scl_s)) begin
        gen_cnt <= gen_cnt - 1'b1;
      end
    end
  end

  // ==========================================================================
  // SDA drive selection; data only changes while SCL is low
  always_comb begin
    next_sda_low = sda_low;
    if (gen_state == iic_ctrl_pkg::GEN_START || gen_state == iic_ctrl_pkg::GEN_STOP_LOW) begin
      next_sda_low = 1'b1;
    end else if (gen_state == iic_ctrl_pkg::GEN_STOP_REL) begin
      next_sda_low = 1'b0;
    end else if (~scl_s) begin
      if (active & ~halt & ack_phase) begin
        next_sda_low = ~transmit & ~ien[iic_ctrl_pkg::IEN_ACKT_BIT];
      end else if (active & ~halt) begin
        next_sda_low = transmit & ~tx_bit;
      end else begin
        next_sda_low = ~line_level;
      end
    end
  end

  // Pin and status outputs, all from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_low <= 1'b0;
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      transfer_halted <= 1'b0;
    end else begin
      sda_low <= next_sda_low;
      sda_oe_n <= ~next_sda_low;
      scl_oe_n <= ~(last_data_fall & wait_en & master) & (wait_cnt <= 1);
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      transfer_halted <= halt;
    end
  end

  // ==========================================================================
  // Interrupt request gating
  irq_gate u_irq_gate (
    .pclk(pclk),
    .presetn(presetn),
    .flags(flags),
    .enables(ien),
    .sync_format(sync_fmt),
    .irq(irq)
  );
endmodule : iic_mode_ctrl
`default_nettype wire

// ===== test/iic_mode_ctrl_checker.sv
// Purpose: Port-level assertions for the mode and interrupt-enable block.
// Assumes: One clock domain; APB answers after one wait state.
// Notes: Bound to the design from the bench file.
`default_nettype none
module iic_mode_ctrl_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_oe_n,
  input wire iic_ctrl_pkg::flags_s flags,
  input wire iic_ctrl_pkg::irq_s irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ========================================
  // Read decode
  logic rd_ok;
  logic at_mode;
  logic at_line;
  assign rd_ok = pready && !pwrite && !pslverr;
  assign at_mode = paddr == ADDR_W'({iic_ctrl_pkg::MODE_IDX, 2'b00});
  assign at_line = paddr == ADDR_W'({iic_ctrl_pkg::LINE_IDX, 2'b00});
  sequence setup_s;
    psel && !penable;
  endsequence
  // Stretch of exactly the wait length
  sequence stretch_s;
    !scl_oe_n throughout (##31 1'b1);
  endsequence
  // Single wait state
  a_apb_one_wait: assert property (setup_s |=> pready && penable)
    else $error("no answer one cycle after setup");
  a_mode_prot_one: assert property (rd_ok && at_mode |-> prdata[3] && prdata[4])
    else $error("mode protect bit read as zero");
  a_line_prot_one: assert property (rd_ok && at_line |-> prdata[4])
    else $error("line protect bit read as zero");
  a_gen_dis_one: assert property (rd_ok && at_line |-> prdata[6])
    else $error("generation disable read as zero");
  a_wait_exact: assert property ($fell(scl_oe_n) |-> stretch_s ##1 scl_oe_n)
    else $error("clock stretch of wrong length");
  a_stop_cause: assert property (irq.stop_req |-> $past(flags.stop_seen))
    else $error("stop request without flag");
  a_nack_cause: assert property (irq.nack_req |-> $past(flags.nack_seen || flags.arb_lost))
    else $error("nack request without flag");
  a_rx_cause: assert property (irq.rx_req |-> $past(flags.rx_full || flags.arb_lost))
    else $error("receive request without flag");
  a_tend_cause: assert property (irq.tx_end_req |-> $past(flags.tx_end))
    else $error("transmit end request without flag");
  a_tempty_cause: assert property (irq.tx_empty_req |-> $past(flags.tx_empty))
    else $error("transmit empty request without flag");
endmodule : iic_mode_ctrl_checker
`default_nettype wire

// ===== test/iic_link_model.sv
// Purpose: Far-side bus device: clocks frames, sends and answers bits.
// Assumes: Open-drain lines with pull-ups; the block only pulls low.
// Notes: SCL stands high between frames.
`default_nettype none
module iic_link_model (
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  output logic scl_line,
  output logic sda_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  logic [8:0] bits = 9'h000;
  // ========================================
  // Wired-AND lines, pull-ups when released
  assign scl_line = scl_drv & scl_oe_n;
  assign sda_line = sda_drv & sda_oe_n;
  // Give SDA back once the block takes it
  always @(negedge sda_oe_n) sda_drv = 1'b1;
  task automatic park(input logic lvl);
    scl_drv = lvl;
  endtask : park
  // Nine pulses; pattern bit sent in each low phase
  task automatic frame(input logic [8:0] pat);
    for (int i = 0; i < 9; i++) begin
      scl_drv = 1'b0;
      sda_drv = pat[8-i];
      #62.5;
      scl_drv = 1'b1;
      // Stretching holds the high phase back
      wait (scl_line === 1'b1);
      bits = {bits[7:0], sda_line};
      #62.5;
    end
  endtask : frame
endmodule : iic_link_model
`default_nettype wire

// ===== test/iic_mode_and_interrupt_enable_bench.sv
// Purpose: Self-checking bench for the mode and interrupt-enable block.
// Assumes: APB master on pclk; partner model on the pins.
// Notes: Expectations follow the register layout.
`default_nettype none
module iic_mode_and_interrupt_enable_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MODE = iic_ctrl_pkg::MODE_IDX;
  localparam logic [7:0] IEN = iic_ctrl_pkg::IEN_IDX;
  localparam logic [7:0] LINE = iic_ctrl_pkg::LINE_IDX;
  localparam logic [7:0] CFG = iic_ctrl_pkg::CFG_IDX;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic scl_in, sda_in, scl_out, sda_out, scl_oe_n, sda_oe_n, transfer_halted;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [7:0] tx_data, rx_data;
  iic_ctrl_pkg::flags_s flags;
  iic_ctrl_pkg::irq_s irq;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int stretch = 0;
  iic_mode_ctrl #(.ADDR_W(12)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_in, .scl_out, .scl_oe_n,
    .sda_in, .sda_out, .sda_oe_n, .tx_data, .rx_data, .transfer_halted, .flags, .irq);
  iic_link_model link_u (.scl_oe_n, .sda_oe_n, .scl_line(scl_in), .sda_line(sda_in));
  // ========================================
  // Clock, stretch count, hang guard
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (!scl_oe_n) stretch <= stretch + 1;
    if (cyc == 8000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input string what, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, exp, rd_q);
  endtask : rd
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
  endtask : ticks
  task automatic bus_start;
    apb(1'b1, LINE, 8'h90);
    ticks(24);
    apb(1'b0, LINE, 8'h00);
    chk("busy", 32'h1, {31'h0, rd_q[7]});
  endtask : bus_start
  task automatic bus_stop;
    apb(1'b1, LINE, 8'h10);
    ticks(40);
    apb(1'b0, LINE, 8'h00);
    chk("idle", 32'h0, {31'h0, rd_q[7]});
  endtask : bus_stop
  // ========================================
  // Scenarios
  task automatic t_regs;
    rd("mode reset", MODE, 32'h18);
    rd("hole", 8'hBC, 32'h0);
    chk("slverr", 32'h1, {31'h0, err_q});
    apb(1'b1, IEN, 8'hFF);
    rd("ien", IEN, 32'hFD);
    link_u.park(1'b0);
    apb(1'b1, MODE, 8'h0F);
    rd("load refused", MODE, 32'h18);
    apb(1'b1, MODE, 8'h07);
    rd("load", MODE, 32'h1F);
    apb(1'b1, MODE, 8'h20);
    link_u.park(1'b1);
    $display("test registers done");
  endtask : t_regs
  task automatic t_irq;
    flags <= 6'b110111;
    apb(1'b1, IEN, 8'h00);
    ticks(2);
    chk("irq off", 32'h0, {27'h0, irq});
    // no counter write in sync format below
    for (int b = 3; b < 8; b++) begin
      // enables set while flags are clear
      flags <= 6'b000000;
      apb(1'b1, IEN, 8'h01 << b);
      flags <= 6'b110111;
      ticks(2);
      chk("irq one", 32'h1 << (7 - b), {27'h0, irq});
    end
    flags <= 6'b001000;
    apb(1'b1, IEN, 8'h30);
    ticks(2);
    chk("loss", 32'h08, {27'h0, irq});
    apb(1'b1, CFG, 8'h01);
    ticks(2);
    chk("overrun", 32'h0C, {27'h0, irq});
    rd("sync count", MODE, 32'h38);
    apb(1'b1, CFG, 8'h00);
    flags <= 6'b000000;
    $display("test interrupts done");
  endtask : t_irq
  // line controls changed only with SCL parked
  task automatic t_line;
    link_u.park(1'b0);
    apb(1'b1, LINE, 8'hB0);
    apb(1'b1, CFG, 8'h02);
    apb(1'b1, LINE, 8'hF0);
    apb(1'b1, LINE, 8'h50);
    ticks(4);
    chk("refused", 32'h1, {31'h0, sda_in});
    apb(1'b1, LINE, 8'h40);
    ticks(4);
    chk("sda low", 32'h0, {31'h0, sda_in});
    apb(1'b1, LINE, 8'h60);
    ticks(4);
    chk("sda high", 32'h1, {31'h0, sda_in});
    chk("outs low", 32'h0, {30'h0, scl_out, sda_out});
    link_u.park(1'b1);
    $display("test line done");
  endtask : t_line
  task automatic t_tx(input logic lsb, input logic wt, input logic [7:0] d, input logic ack);
    logic [7:0] exp;
    for (int i = 0; i < 8; i++) exp[i] = lsb ? d[7-i] : d[i];
    tx_data <= d;
    apb(1'b1, CFG, 8'h06);
    apb(1'b1, MODE, {lsb, wt, 6'h00});
    apb(1'b1, IEN, 8'h04);
    bus_start();
    stretch <= 0;
    link_u.frame({8'hFF, ack});
    chk("wire data", {24'h0, exp}, {24'h0, link_u.bits[8:1]});
    chk("stretch", wt ? 32'(iic_ctrl_pkg::WAIT_CYCLES) : 32'h0, 32'(stretch));
    rd("count clear", MODE, {24'h0, lsb, wt, 6'h18});
    rd("ack seen", IEN, {28'h0, 2'b01, ack, 1'b0});
    chk("halted", {31'h0, ack}, {31'h0, transfer_halted});
    bus_stop();
    $display("test transmit done");
  endtask : t_tx
  task automatic t_rx(input logic ackv);
    apb(1'b1, CFG, 8'h02);
    apb(1'b1, MODE, 8'h00);
    apb(1'b1, IEN, {7'h00, ackv});
    bus_start();
    link_u.frame({8'h96, 1'b1});
    chk("ack sent", {31'h0, ackv}, {31'h0, link_u.bits[0]});
    chk("rx data", 32'h96, {24'h0, rx_data});
    bus_stop();
    $display("test receive done");
  endtask : t_rx
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_data = 8'h00;
    flags = 6'b000000;
    ticks(10);
    presetn <= 1'b1;
    t_regs();
    t_irq();
    t_line();
    t_tx(1'b0, 1'b1, 8'hC1, 1'b1);
    t_tx(1'b1, 1'b0, 8'h35, 1'b0);
    t_rx(1'b1);
    t_rx(1'b0);
    wrap_up();
  end
endmodule : iic_mode_and_interrupt_enable_bench
bind iic_mode_ctrl iic_mode_ctrl_checker #(.ADDR_W(ADDR_W)) chk_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .scl_oe_n, .flags, .irq);
`default_nettype wire
